/* rtl/ssar_pkg.sv */
// constants, types and gray helpers for the serial sar readout block
// assumes a 250 MHz reference clock and a host-driven shift clock
package ssar_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int REF_CLK_MHZ = 250;
  localparam int INT_CLK_KHZ = 4000;
  // half period of the internal system clock in reference cycles
  localparam int HALF_PERIOD_CYC = (REF_CLK_MHZ * 1000) / (2 * INT_CLK_KHZ);
  localparam int CONV_MAX_NS = 17000;
  localparam int CONV_PERIODS = 36;
  localparam int TRIAL_PERIODS = 4;
  localparam int TRIAL_SPAN = 32;

  // ************************************************************
  // result and access
  // ************************************************************
  localparam int RESULT_BITS = 8;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [3:0] SHIFT_EDGES = 4'h8;
  localparam logic [1:0] FILTER_RISES = 2'h2;
  localparam logic [1:0] FILTER_FALLS = 2'h1;
  localparam int EDGE_CNT_BITS = 4;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_FILTER,
    ACC_SHIFT
  } ssar_acc_t;

  // gray code helpers, used on both sides of the crossing
  function automatic logic [3:0] ssar_gray2bin(input logic [3:0] g);
    logic [3:0] b;
    b[3] = g[3];
    for (int i = 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [3:0] ssar_bin2gray(input logic [3:0] b);
    return b ^ (b >> 1);
  endfunction

endpackage

/* rtl/ssar_link.sv */
// shift clock side: counts falling edges of the shift clock during a select
// assumes select high clears the count; output is gray so it may cross
`timescale 1ns/1ps
`default_nettype none

module ssar_link (
  input wire logic io_clk_i,
  input wire logic cs_n_i,
  output logic [ssar_pkg::EDGE_CNT_BITS-1:0] gray_o
);
  import ssar_pkg::*;

  typedef struct packed {
    logic [3:0] gray;
  } ssar_link_t;

  ssar_link_t s;
  ssar_link_t next_s;

  // ************************************************************
  // edge counter
  // ************************************************************
  // saturate at the eighth edge so stray extra edges change nothing
  always_comb begin
    logic [3:0] b;
    b = ssar_gray2bin(s.gray);
    next_s = s;
    if (b < SHIFT_EDGES) begin
      b = 4'(b + 4'h1); // RULE8
    end
    next_s.gray = ssar_bin2gray(b);
  end

  // select high ends the frame; the clock may stand still afterwards
  always_ff @(negedge io_clk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      s <= '0; // RULE15
    end else begin
      s <= next_s;
    end
  end

  assign gray_o = s.gray;

endmodule

`default_nettype wire

/* rtl/ssar_top.sv */
// serial readout and successive-approximation control of an 8-bit converter
// assumes the held input code is stable around conversion start; host keeps
// the select and shift clock timing limits
// the link's edge counter clears itself whenever select is high
//
// Overview of operation
// RULE1: eight-bit result by successive approximation
// RULE2: only select and shift clock control it
// RULE3: serial output is three-state driver
// RULE4: conversion paced by free internal 4 MHz clock
// RULE5: host limits shift clock frequency
// RULE6: sample tracks during access, held at start
// RULE7: msb driven once select is low
// RULE8: next seven bits on falling edges
// RULE9: eighth falling edge starts new conversion
// RULE10: conversion lasts 36 internal clock periods
// RULE11: next access shows the just-finished result
// RULE12: select filtered: two rises, one fall
// RULE13: host keeps select high during conversion
// RULE14: host waits after select before clocking
// RULE15: select high: output released, edges ignored
`timescale 1ns/1ps
`default_nettype none

module ssar_top (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic IO_CLK_I,
  input wire logic CS_N_I,
  input wire logic [ssar_pkg::RESULT_BITS-1:0] ANALOG_CODE_I,
  output logic DATA_O,
  output logic DATA_OE_O
);
  import ssar_pkg::*;

  typedef struct packed {
    logic sel_s1;
    logic sel_s2;
    logic sel_s3;
    logic sel;
    logic [3:0] gray_s1;
    logic [3:0] gray_s2;
    logic [3:0] gray_s3;
    logic [3:0] edges;
    logic [5:0] div_cnt;
    logic phase;
    ssar_acc_t acc;
    logic [1:0] rises;
    logic [1:0] falls;
    logic fired;
    logic busy;
    logic [5:0] conv_cnt;
    logic [7:0] hold;
    logic [7:0] sar;
    logic [7:0] result;
    logic data;
    logic oe;
  } ssar_state_t;

  localparam logic [5:0] HALF_LAST = 6'(HALF_PERIOD_CYC - 1);
  localparam logic [5:0] CONV_LAST = 6'(CONV_PERIODS - 1);
  localparam logic [5:0] TRIAL_END = 6'(TRIAL_SPAN);
  localparam logic [1:0] TRIAL_LAST = 2'(TRIAL_PERIODS - 1);

  // bit position counted down from the msb, shared by readout and trials
  function automatic logic [2:0] msb_index(input logic [2:0] step);
    return 3'(3'h7 - step);
  endfunction

  ssar_state_t s;
  ssar_state_t next_s;
  logic [3:0] link_gray;

  // ************************************************************
  // shift clock domain
  // ************************************************************
  ssar_link u_link (
    .io_clk_i(IO_CLK_I),
    .cs_n_i(CS_N_I),
    .gray_o(link_gray)
  );

  // ************************************************************
  // reference clock domain
  // ************************************************************
  // next value of every flop in the reference domain
  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic [2:0] bit_idx;
    logic [7:0] trial;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    bit_idx = 3'h0;
    trial = 8'h00;
    next_s = s;

    // three-stage synchronisers, a change counts once stages two and three agree
    next_s.sel_s1 = ~CS_N_I;
    next_s.sel_s2 = s.sel_s1;
    next_s.sel_s3 = s.sel_s2;
    if (s.sel_s2 == s.sel_s3) begin
      next_s.sel = s.sel_s3;
    end
    next_s.gray_s1 = link_gray;
    next_s.gray_s2 = s.gray_s1;
    next_s.gray_s3 = s.gray_s2;
    // gray moves one bit per edge, so agreement means a clean count
    if (s.gray_s2 == s.gray_s3) begin
      next_s.edges = ssar_gray2bin(s.gray_s3);
    end

    // free-running internal system clock, never stopped by the host
    if (s.div_cnt == HALF_LAST) begin
      next_s.div_cnt = 6'h00;
      next_s.phase = ~s.phase; // RULE4
      rise = ~s.phase;
      fall = s.phase;
    end else begin
      next_s.div_cnt = 6'(s.div_cnt + 6'h01);
    end

    // access sequencer
    case (s.acc)
      ACC_IDLE: begin
        // deselected: pin released, wait for a synced select
        next_s.oe = 1'b0; // RULE15
        if (s.sel) begin // RULE2
          next_s.acc = ACC_FILTER;
          next_s.rises = 2'h0;
          next_s.falls = 2'h0;
        end
      end
      ACC_FILTER: begin
        // short glitches on select never reach the output
        if (!s.sel) begin
          next_s.acc = ACC_IDLE;
        end else begin
          if (rise && s.rises != FILTER_RISES) begin
            next_s.rises = 2'(s.rises + 2'h1);
          end
          if (fall && s.falls != FILTER_FALLS) begin
            next_s.falls = 2'(s.falls + 2'h1);
          end
          if (next_s.rises == FILTER_RISES && next_s.falls == FILTER_FALLS) begin // RULE12
            next_s.acc = ACC_SHIFT;
            next_s.fired = 1'b0;
          end
        end
      end
      ACC_SHIFT: begin
        if (!s.sel) begin
          next_s.acc = ACC_IDLE;
          next_s.oe = 1'b0; // RULE15
        end else begin
          // enable and bit are loaded on one edge, so the pin never shows stale data
          next_s.oe = 1'b1; // RULE3
          // edge count is zero here by host setup wait, so msb shows first
          if (s.edges < SHIFT_EDGES) begin // RULE14
            bit_idx = msb_index(s.edges[2:0]);
            next_s.data = s.result[bit_idx]; // RULE7 RULE8 RULE11
          end else if (!s.fired) begin
            next_s.fired = 1'b1;
            // a start during a running conversion is dropped; host waits
            start = ~s.busy; // RULE9 RULE13
          end
        end
      end
      default: begin
        next_s.acc = ACC_IDLE;
        next_s.oe = 1'b0;
      end
    endcase

    // conversion: sampled input is held from the start edge on
    if (start) begin
      next_s.busy = 1'b1;
      next_s.conv_cnt = 6'h00;
      next_s.hold = ANALOG_CODE_I; // RULE6
      next_s.sar = 8'h00;
    end else if (s.busy && rise) begin
      next_s.conv_cnt = 6'(s.conv_cnt + 6'h01);
      // one bit trial every four periods, msb first
      if (s.conv_cnt[1:0] == TRIAL_LAST && s.conv_cnt < TRIAL_END) begin
        bit_idx = msb_index(s.conv_cnt[4:2]);
        trial = s.sar | (8'h01 << bit_idx);
        if (s.hold >= trial) begin
          next_s.sar = trial; // RULE1
        end
      end
      // last period: the finished code replaces what the next access shows
      if (s.conv_cnt == CONV_LAST) begin
        next_s.busy = 1'b0; // RULE10
        next_s.result = s.sar; // RULE11
      end
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  // synchronous reset; the result reads zero until a conversion ends
  always_ff @(posedge REF_CLK_I) begin
    if (!RESET_N_I) begin
      s <= '0;
      s.result <= RESULT_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // pins
  // ************************************************************
  // pins come straight from state flops
  assign DATA_O = s.data;
  assign DATA_OE_O = s.oe;

endmodule

`default_nettype wire

/* tb/ssar_host.sv */
// serial host model: select, shift clock, capture of the result byte
// assumes the bench resolves the three-state data line
`timescale 1ns/1ps
`default_nettype none
module ssar_host (
  output logic cs_n_o,
  output logic io_clk_o,
  input wire logic data_i,
  output logic [7:0] byte_o,
  output logic done_o
);
  // 17 link clocks of 15 ns: a 510 ns shift period, clear of the fastest legal rate
  localparam int HALF_CYC = 17;
  localparam int SETUP_CYC = 100;
  localparam int GAP_CYC = 1167;
  logic lclk = 1'b0;
  // bench link clock, free running and out of step with the reference clock
  always #7.5 lclk = ~lclk;
  // one falling shift edge while select is high clears the edge counter before the first access
  initial begin
    cs_n_o = 1'b1;
    io_clk_o = 1'b1;
    done_o = 1'b0;
    byte_o = 8'h00;
    #9 io_clk_o = 1'b0;
  end
  // only select and shift clock ever move
  task automatic access(input int edges, input int pre);
    repeat (pre) begin
      io_clk_o = 1'b1;
      repeat (HALF_CYC) @(posedge lclk);
      io_clk_o = 1'b0;
      repeat (HALF_CYC) @(posedge lclk);
    end
    cs_n_o = 1'b0;
    repeat (SETUP_CYC) @(posedge lclk);
    for (int i = 0; i < edges; i++) begin
      io_clk_o = 1'b1;
      repeat (HALF_CYC) @(posedge lclk);
      byte_o[7-i] = data_i;
      io_clk_o = 1'b0;
      repeat (HALF_CYC) @(posedge lclk);
    end
    cs_n_o = 1'b1;
    if (edges == 8) begin
      done_o = 1'b1;
      #1 done_o = 1'b0;
    end
    repeat (GAP_CYC) @(posedge lclk);
  endtask
  // select pulse far shorter than the noise filter: the pin must stay released
  task automatic blip();
    cs_n_o = 1'b0;
    repeat (4) @(posedge lclk);
    cs_n_o = 1'b1;
    repeat (SETUP_CYC) @(posedge lclk);
  endtask
endmodule
`default_nettype wire

/* tb/ssar_top_assertions.sv */
// pin-level checker of the serial readout
// assumes it is bound to ssar_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ssar_chk (
  input wire logic REF_CLK_I,
  input wire logic RESET_N_I,
  input wire logic IO_CLK_I,
  input wire logic CS_N_I,
  input wire logic [ssar_pkg::RESULT_BITS-1:0] ANALOG_CODE_I,
  input wire logic DATA_O,
  input wire logic DATA_OE_O
);
  import ssar_pkg::*;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // select just fell and is still inside the noise filter
  sequence sel_settle;
    $fell(CS_N_I) ##1 !CS_N_I [*8];
  endsequence
  sequence bus_quiet;
    (DATA_OE_O && $stable(IO_CLK_I)) [*8];
  endsequence
  out_reset_a: assert property (disable iff (1'b0) !RESET_N_I |=> !DATA_OE_O && !DATA_O)
    else $error("outputs not cleared by reset");
  oe_early_a: assert property (sel_settle |-> !DATA_OE_O)
    else $error("enable before filter");
  oe_filter_a: assert property ($rose(DATA_OE_O) |-> !CS_N_I && !$past(CS_N_I, 60))
    else $error("enable without settled select");
  oe_on_a: assert property ($fell(CS_N_I) |-> ##[1:200] (DATA_OE_O || CS_N_I))
    else $error("msb not driven");
  oe_stays_a: assert property (DATA_OE_O && !CS_N_I |=> DATA_OE_O)
    else $error("enable dropped");
  oe_off_a: assert property (CS_N_I [*7] |-> !DATA_OE_O)
    else $error("pin driven with select high");
  oe_idle_a: assert property (CS_N_I && !DATA_OE_O |=> !DATA_OE_O)
    else $error("enable rose with select high");
  data_hold_a: assert property (bus_quiet |-> $stable(DATA_O))
    else $error("data moved without shift edge");
endmodule
bind ssar_top ssar_chk chk_u (.REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .IO_CLK_I(IO_CLK_I),
  .CS_N_I(CS_N_I), .ANALOG_CODE_I(ANALOG_CODE_I), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O));
`default_nettype wire

/* tb/tb_serial_sar_adc_readout.sv */
// self-checking bench of the serial readout
// assumes ssar_host drives select and shift clock, 250 MHz reference
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t bad byte", $time); end end
module tb_serial_sar_adc_readout;
  import ssar_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] code = 8'h00;
  logic [7:0] exp_v = 8'h00;
  logic [7:0] got;
  logic [7:0] q[$];
  logic io_clk, cs_n, data, data_oe, done;
  int err_total = 0;
  int checks_done = 0;
  int unsigned seed = 88379;
  wire data_w;
  always #2 ref_clk = ~ref_clk;
  // no pull on the pin: a released line floats and fails compares
  assign data_w = data_oe ? data : 1'bz;
  ssar_top dut_u (.REF_CLK_I(ref_clk), .RESET_N_I(reset_n), .IO_CLK_I(io_clk), .CS_N_I(cs_n),
    .ANALOG_CODE_I(code), .DATA_O(data), .DATA_OE_O(data_oe));
  ssar_host host_u (.cs_n_o(cs_n), .io_clk_o(io_clk), .data_i(data_w), .byte_o(got), .done_o(done));
  function automatic int unsigned xs(input int unsigned x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic wrap_up();
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // each full read is judged against the oldest note
  always @(posedge done) begin
    `CHK(got, q.pop_front())
  end
  // ****************
  // main sequence: pre-pulses, short read, mid-run reset
  // ****************
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (i == 4) begin
        @(posedge ref_clk);
        #1 reset_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        exp_v = 8'h00;
      end
      seed = xs(seed);
      @(posedge ref_clk);
      #1 code = (i == 3) ? 8'hff : seed[7:0];
      if (i != 2) q.push_back(exp_v);
      if (i == 1) host_u.blip();
      host_u.access(i == 2 ? 5 : 8, i == 1 ? 3 : 0);
      if (i != 2) exp_v = code;
    end
    // every noted read must have been answered
    `CHK(q.size(), 0)
    wrap_up();
  end
  // hang guard
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
